//--- design/slr_params.svh
// Constants for the sub-link router and timing encoder
`ifndef SLR_PARAMS_SVH
`define SLR_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SLR_OFF_ENABLE   12'h000
`define SLR_OFF_WIDTH    12'h004
`define SLR_OFF_OPTION   12'h008
`define SLR_OFF_MODE     12'h00C
`define SLR_OFF_STATUS   12'h010
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SLR_MODE_WIDE_BIT   0
`define SLR_MODE_CTL_BIT    1
`define SLR_MODE_B24_BIT    2
`define SLR_RST_ENABLE      32'h0000_0000
`define SLR_RST_WIDTH       32'h0000_0000
`define SLR_RST_OPTION      32'h0000_0000
`define SLR_RST_MODE        32'h0000_0000
// ----------------------------------------------------------------
// Frame geometry and timing
// ----------------------------------------------------------------
`define SLR_PAYLOAD_BITS    80
`define SLR_GROUP_BITS      16
`define SLR_NUM_GROUPS      5
`define SLR_TEST_PULSE_BC   16
`define SLR_INFO_BYTES      26
`define SLR_IDLE_BYTE       8'h55
`endif

//--- design/slr_pkg.sv
// Types shared by the sub-link router and timing encoder
package slr_pkg;
   // Sub-link width per group
   typedef enum logic [1:0] {
      SLR_W2   = 2'b00,
      SLR_W4   = 2'b01,
      SLR_W8   = 2'b10,
      SLR_W16  = 2'b11
   } slr_width_e;
   // Decoded timing inputs of one crossing
   typedef struct packed {
      logic       accept;
      logic       bchan;
      logic [7:0] brcst;
   } slr_ttc_s;
endpackage

//--- design/slr_ttc_enc.sv
// Timing option encoder for one to-front-end sub-link group
`include "slr_params.svh"
module slr_ttc_enc (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Crossing strobe and decoded timing
   input wire logic bc_en,
   input wire slr_pkg::slr_ttc_s ttc,
   input wire logic [2:0] option,
   // Encoded 8 bits, bit 0 sent first
   output logic [7:0] code
);
   import slr_pkg::*;
   typedef struct packed {
      logic [4:0] tp_cnt;
      logic       ocr_2nd;
      logic [7:0] code;
   } slr_enc_s;
   slr_enc_s st, next_st;
   logic bunch_counter_reset, event_counter_reset, tp, b3;
   always_comb begin
      next_st = st;
      bunch_counter_reset = ttc.brcst[0];
      event_counter_reset = ttc.brcst[1];
      tp = 1'b0;
      b3 = ttc.brcst[3];
      if (bc_en) begin
         // Broadcast bits are levels, repeated by the source
         if (option == 3'd7) begin
            // Two consecutive bunch resets form an orbit reset
            next_st.ocr_2nd = ttc.brcst[7];
            bunch_counter_reset = ttc.brcst[0] | ttc.brcst[7] | st.ocr_2nd;
            // Test pulse held for sixteen crossings
            if (ttc.brcst[2]) begin
               next_st.tp_cnt = 5'(`SLR_TEST_PULSE_BC - 1);
            end else if (st.tp_cnt != 5'h00) begin
               next_st.tp_cnt = st.tp_cnt - 5'h01;
            end
            tp = ttc.brcst[2] | (st.tp_cnt != 5'h00);
         end else begin
            next_st.ocr_2nd = 1'b0;
            next_st.tp_cnt = 5'h00;
            tp = ttc.brcst[2];
         end
         // Index 0 is bunch reset, index 1 event reset
         case (option)
            3'd0: next_st.code = {6'h00, ttc.bchan, ttc.accept};
            3'd1: next_st.code = {4'h0, ttc.bchan, event_counter_reset, bunch_counter_reset,
                                  ttc.accept};
            3'd2: next_st.code = {4'h0, ttc.brcst[2], event_counter_reset, bunch_counter_reset,
                                  ttc.accept};
            3'd3: next_st.code = {ttc.bchan, ttc.brcst[5:2], event_counter_reset, bunch_counter_reset,
                                  ttc.accept};
            3'd5: next_st.code = {4'h0, {4{bunch_counter_reset}}};
            3'd6: next_st.code = {6'h00, {2{bunch_counter_reset}}};
            // Copied bits; test pulse stretched under option 7 only
            3'd4, 3'd7: next_st.code = {ttc.accept, b3, tp, event_counter_reset, bunch_counter_reset,
                                        ttc.accept, ttc.brcst[5], event_counter_reset};
            default: next_st.code = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign code = st.code;
   // Crossings are several clocks apart, so the repeat is tracked by state
   AST_OCR_TWICE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en && option == 3'd7 && (ttc.brcst[7] || st.ocr_2nd) |=> code[3])
      else $error("second bunch reset missing");
   AST_TP_HOLD: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en && option == 3'd7 && ttc.brcst[2] |=> st.tp_cnt == 5'd15)
      else $error("test pulse hold not loaded");
   AST_OPT0: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en && option == 3'd0 |=> code == {6'h00, $past(ttc.bchan),
      $past(ttc.accept)})
      else $error("option 0 layout wrong");
   COV_OPT7_TP: cover property (@(posedge clk_sys) disable iff (!nrst)
      option == 3'd7 && st.tp_cnt == 5'd1);
endmodule

//--- design/slr_hdlc_tx.sv
// Two-bit HDLC sender: flags when idle, stuffing after five ones
`include "slr_params.svh"
module slr_hdlc_tx (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Crossing strobe
   input wire logic bc_en,
   // Byte source
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   output logic in_ready,
   // Two-bit output, bit 0 first
   output logic [1:0] dout
);
   import slr_pkg::*;
   typedef struct packed {
      logic [7:0] sh;
      logic [3:0] left;
      logic       flag;
      logic [2:0] ones;
      logic [1:0] dout;
   } slr_hdlc_s;
   slr_hdlc_s st, next_st;
   logic [1:0] o;
   logic bit_v;
   integer i;
   always_comb begin
      next_st = st;
      o = 2'b00;
      bit_v = 1'b0;
      in_ready = bc_en && st.left == 4'h0 && !st.flag;
      if (bc_en) begin
         for (i = 0; i < 2; i++) begin
            if (next_st.left == 4'h0) begin
               if (in_valid && !next_st.flag && i == 0) begin
                  next_st.sh = in_data;
               end else begin
                  next_st.sh = 8'h7E;
                  next_st.flag = 1'b1;
               end
               next_st.left = 4'h8;
            end
            if (!next_st.flag && next_st.ones == 3'd5) begin
               bit_v = 1'b0;
               next_st.ones = 3'd0;
            end else begin
               bit_v = next_st.sh[0];
               next_st.sh = {1'b0, next_st.sh[7:1]};
               next_st.left = next_st.left - 4'h1;
               next_st.ones = (bit_v && !next_st.flag) ?
                  next_st.ones + 3'd1 : 3'd0;
               if (next_st.left == 4'h0) begin
                  next_st.flag = 1'b0;
               end
            end
            o[i] = bit_v;
         end
         next_st.dout = o;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign dout = st.dout;
endmodule

//--- design/slr_router.sv
// Sub-link router with timing encoder and register slave
//
// Functional notes
// - Sub-links may be 2, 4 or 8 bits per crossing.
// - A 16-bit sub-link width is unsupported; such links forward nothing and send no idle.
// - Normal frame payload is 80 bits; unassigned bits stay unused.
// - Wide framing with 112 bits is not implemented.
// - Payload splits into 16-bit groups of equal-width sub-links.
// - Each group has eight endpoints; width decides which are used.
// - Each sub-link has an 11-bit identifier encoding its endpoint; only host_id0 is output here, tied to zero.
// - Wide-stream mode forwards the whole payload undivided.
// - Restricted build limits widths; group 3 has no outbound links; its disabled links still send idle here.
// - A virtual sub-link emits a 26-byte packet per trigger accept; accepts arriving during a packet are dropped here.
// - Bit 0 of each sub-link is sent first.
// - Option 0: accept on bit 0, raw B-channel on bit 1.
// - Options 1 and 2: accept, bunch reset, event reset, then bit 3.
// - Broadcast 0 is bunch reset, 1 event reset, 7..2 user bits.
// - Option 3 layout; options 5 and 6 repeat bunch reset.
// - Options 4 and 7 copy some timing bits; only option 7 stretches.
// - Option 7: broadcast 7 gives two consecutive bunch resets.
// - Option 7: test pulse request held sixteen crossings.
// - User broadcast bits follow the source, no latching or toggle.
// - Slow-control links are 2-bit HDLC, encoded here.
// - Slow control needs one enabled HDLC link each direction.
// - External control link is 2-bit HDLC or 2-bit 8b/10b; the 8b/10b setting here drives zeros.
// - Control and timing-to-host data always time out at once.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`include "slr_params.svh"
module slr_router #(
   parameter int NGRP = `SLR_NUM_GROUPS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Crossing strobe and decoded timing
   input wire logic bc_en,
   input wire slr_pkg::slr_ttc_s ttc,
   // Received payload, normal framing only
   input wire logic [79:0] rx_payload,
   // To-host sub-link data
   output logic [79:0] host_data,
   output logic [39:0] host_valid,
   output logic [10:0] host_id0,
   output logic wide_valid,
   // To-host control channel and its flush
   output logic [1:0] ctl_rx,
   output logic ctl_flush,
   // Slow-control byte source for the control link
   input wire logic ctl_tx_valid,
   input wire logic [7:0] ctl_tx_data,
   output logic ctl_tx_ready,
   output logic [1:0] ctl_tx,
   // Outgoing frame payload
   output logic [79:0] tx_payload,
   // Trigger information packet stream
   output logic [7:0] info_data,
   output logic info_valid,
   output logic info_last,
   output logic info_flush
);
   import slr_pkg::*;
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        aw_got;
      logic        w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [31:0] enable;
      logic [31:0] width;
      logic [31:0] option;
      logic [31:0] mode;
      logic [79:0] host_data;
      logic [39:0] host_valid;
      logic        wide_valid;
      logic [1:0]  ctl_rx;
      logic        ctl_flush;
      logic [79:0] tx_payload;
      logic [4:0]  info_cnt;
      logic [31:0] trig_cnt;
      logic [7:0]  info_data;
      logic        info_valid;
      logic        info_last;
      logic        info_flush;
   } slr_top_s;
   slr_top_s st, next_st;
   logic [7:0] enc_code [NGRP];
   logic [1:0] hdlc_out;
   logic aw_take, w_take, ar_take;
   logic [31:0] status;
   slr_width_e gw;
   logic [2:0] ep;
   integer g, k;
   // ----------------------------------------------------------------
   // Timing encoders and control-link sender
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NGRP; gi++) begin : g_enc
         slr_ttc_enc u_enc (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .bc_en(bc_en),
            .ttc(ttc),
            .option(st.option[3*gi +: 3]),
            .code(enc_code[gi])
         );
      end
   endgenerate
   slr_hdlc_tx u_hdlc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .bc_en(bc_en),
      .in_valid(ctl_tx_valid),
      .in_data(ctl_tx_data),
      .in_ready(ctl_tx_ready),
      .dout(hdlc_out)
   );
   // Control link is driven to zero when the control mode bit is set
   assign ctl_tx = st.mode[`SLR_MODE_CTL_BIT] ? 2'b00 : hdlc_out;
   // ----------------------------------------------------------------
   // Routing and bus
   // ----------------------------------------------------------------
   assign aw_take = s_axi_awvalid && !st.aw_got && !st.bvalid;
   assign w_take = s_axi_wvalid && !st.w_got && !st.bvalid;
   assign ar_take = s_axi_arvalid && !st.rvalid;
   assign status = {st.trig_cnt[27:0], 1'b0, st.mode[2:0]};
   always_comb begin
      next_st = st;
      gw = SLR_W2;
      ep = 3'd0;
      // Bus: address and data in either order, response after both
      if (aw_take) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (next_st.aw_got && next_st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = 2'b00;
         for (k = 0; k < 4; k++) begin
            if (next_st.wstrb[k]) begin
               case (next_st.awaddr)
                  `SLR_OFF_ENABLE: next_st.enable[8*k +: 8] =
                     next_st.wdata[8*k +: 8];
                  `SLR_OFF_WIDTH: next_st.width[8*k +: 8] =
                     next_st.wdata[8*k +: 8];
                  `SLR_OFF_OPTION: next_st.option[8*k +: 8] =
                     next_st.wdata[8*k +: 8];
                  `SLR_OFF_MODE: next_st.mode[8*k +: 8] =
                     next_st.wdata[8*k +: 8];
                  default: next_st.bresp = 2'b10;
               endcase
            end
         end
         if (!(next_st.awaddr inside {`SLR_OFF_ENABLE, `SLR_OFF_WIDTH,
             `SLR_OFF_OPTION, `SLR_OFF_MODE})) begin
            next_st.bresp = 2'b10;
         end
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (ar_take) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = 2'b00;
         case (s_axi_araddr)
            `SLR_OFF_ENABLE: next_st.rdata = st.enable;
            `SLR_OFF_WIDTH: next_st.rdata = st.width;
            `SLR_OFF_OPTION: next_st.rdata = st.option;
            `SLR_OFF_MODE: next_st.rdata = st.mode;
            `SLR_OFF_STATUS: next_st.rdata = status;
            default: begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = 2'b10;
            end
         endcase
      end
      // Per-crossing routing
      next_st.info_valid = 1'b0;
      next_st.info_last = 1'b0;
      next_st.info_flush = 1'b0;
      next_st.ctl_flush = 1'b0;
      if (bc_en) begin
         next_st.host_valid = '0;
         next_st.wide_valid = 1'b0;
         next_st.host_data = '0;
         next_st.tx_payload = '0;
         if (st.mode[`SLR_MODE_WIDE_BIT]) begin
            // Whole payload forwarded as one stream
            next_st.host_data = rx_payload;
            next_st.wide_valid = 1'b1;
         end else begin
            // Groups of 16 bits inside the 80-bit payload
            for (g = 0; g < NGRP; g++) begin
               gw = slr_width_e'(st.width[2*g +: 2]);
               if (st.mode[`SLR_MODE_B24_BIT]) begin
                  // Restricted build limits selectable widths
                  if (g == 4 || (g >= 2 && gw == SLR_W2)) begin
                     gw = SLR_W8;
                  end
               end
               // Endpoints in use depend on width
               for (k = 0; k < 8; k++) begin
                  ep = 3'(k);
                  if (st.enable[8*g + k] && gw != SLR_W16 &&
                      ((gw == SLR_W2) || (gw == SLR_W4 && !ep[0]) ||
                       (gw == SLR_W8 && ep[1:0] == 2'b00))) begin
                     next_st.host_valid[8*g + k] = 1'b1;
                     next_st.host_data[16*g + 2*k +: 2] =
                        rx_payload[16*g + 2*k +: 2];
                     // Outgoing option code, bit 0 leads
                     if (!(st.mode[`SLR_MODE_B24_BIT] && g == 3)) begin
                        case (gw)
                           SLR_W2: next_st.tx_payload[16*g + 2*k +: 2] =
                              enc_code[g][1:0];
                           SLR_W4: next_st.tx_payload[16*g + 2*k +: 4] =
                              enc_code[g][3:0];
                           default: next_st.tx_payload[16*g + 2*k +: 8] =
                              enc_code[g];
                        endcase
                     end
                  end else if (gw != SLR_W16 && ((gw == SLR_W2) ||
                     (gw == SLR_W4 && !ep[0]) ||
                     (gw == SLR_W8 && ep[1:0] == 2'b00))) begin
                     // Disabled link sends idle outward
                     next_st.tx_payload[16*g + 2*k +: 2] = 2'b01;
                  end
               end
               // Wider links hold the data of their lower endpoints
               for (k = 0; k < 8; k++) begin
                  if (next_st.host_valid[8*g + k]) begin
                     next_st.host_data[16*g + 2*k +: 8] = (gw == SLR_W8) ?
                        rx_payload[16*g + 2*k +: 8] :
                        (gw == SLR_W4) ? {4'h0, rx_payload[16*g+2*k +: 4]} :
                        {6'h00, rx_payload[16*g + 2*k +: 2]};
                  end
               end
            end
         end
         next_st.ctl_rx = rx_payload[1:0];
         // Control data flushed every crossing
         next_st.ctl_flush = 1'b1;
      end
      // Information packet per trigger accept; accepts during a packet are ignored
      if (st.info_cnt != 5'd0) begin
         next_st.info_valid = 1'b1;
         next_st.info_data = (st.info_cnt > 5'd22) ?
            st.trig_cnt[8*(5'd26 - st.info_cnt) +: 8] : 8'h00;
         next_st.info_cnt = st.info_cnt - 5'd1;
         next_st.info_last = (st.info_cnt == 5'd1);
         next_st.info_flush = (st.info_cnt == 5'd1);
      end else if (bc_en && ttc.accept && st.enable[31]) begin
         next_st.info_cnt = 5'(`SLR_INFO_BYTES);
         next_st.trig_cnt = st.trig_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready = !st.w_got && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign host_data = st.host_data;
   assign host_valid = st.host_valid;
   // Identifier: link index, group and endpoint
   assign host_id0 = {5'h00, 3'd0, 3'd0};
   assign wide_valid = st.wide_valid;
   assign ctl_rx = st.ctl_rx;
   assign ctl_flush = st.ctl_flush;
   assign tx_payload = st.tx_payload;
   assign info_data = st.info_data;
   assign info_valid = st.info_valid;
   assign info_last = st.info_last;
   assign info_flush = st.info_flush;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_W16_OFF: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en && !st.mode[0] && st.width[1:0] == 2'b11 |=>
      host_valid[7:0] == 8'h00)
      else $error("16-bit link forwarded data");
   AST_DIS_IDLE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en && !st.mode[0] && !st.mode[2] && st.width[1:0] == 2'b00 &&
      !st.enable[0] |=> tx_payload[1:0] == 2'b01 && !host_valid[0])
      else $error("disabled link not idle");
   AST_WIDE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en && st.mode[0] |=> wide_valid && host_valid == '0)
      else $error("wide stream not forwarded");
   AST_INFO_LEN: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      $rose(st.info_cnt == 5'd26) |-> ##26 info_last)
      else $error("info packet length wrong");
   AST_CTL_FLUSH: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      bc_en |=> ctl_flush)
      else $error("control channel not flushed");
   AST_BRESP: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else
      $error("write response dropped");
   COV_WIDE: cover property (@(posedge clk_sys) wide_valid);
   COV_INFO: cover property (@(posedge clk_sys) info_last);
   COV_WR: cover property (@(posedge clk_sys) s_axi_bvalid && s_axi_bready);
endmodule

//--- verif/slr_fe_model.sv
// Front-end model: crossing strobe and received frame payload
module slr_fe_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link side
   output logic bc_en,
   output logic [79:0] rx_payload
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   // ----------------------------------------
   // One crossing every four clocks
   // ----------------------------------------
   // Payload turns over right after it is sampled, then holds for four clocks
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt <= 2'd0;
         bc_en <= 1'b0;
         rx_payload <= '0;
      end else begin
         cnt <= cnt + 2'd1;
         bc_en <= (cnt == 2'd2);
         if (bc_en) begin
            rx_payload <= {$urandom, $urandom, 16'($urandom)};
         end
      end
   end
endmodule

//--- verif/slr_router_test.sv
// Self-checking bench for the sub-link router and timing encoder
`include "slr_params.svh"
module slr_router_test;
   timeunit 1ns;
   timeprecision 1ps;
   import slr_pkg::*;
   logic clk_sys = 0, nrst = 0, bc_en, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, wide_valid, ctl_flush, ctl_tx_ready, ctl_tx_valid = 0;
   logic info_valid, info_last, info_flush;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, ctl_rx, ctl_tx, rd_r;
   logic [79:0] rx_payload, host_data, tx_payload, rxs;
   logic [39:0] host_valid;
   logic [10:0] host_id0;
   logic [7:0] ctl_tx_data = 0, info_data, msk;
   slr_ttc_s ttc = '0, t;
   int n_fail = 0, n_compared = 0, cyc = 0, o, n, k;
   int opts[7] = '{0, 1, 2, 3, 4, 5, 6};
   slr_fe_model fe (.*);
   slr_router uut (.*);
   initial forever #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [79:0] s, logic [79:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // ----------------------------------------
   // Bus cycles, entered just after a rising edge
   // ----------------------------------------
   task automatic wr(logic [11:0] a, logic [31:0] d);
      bit ad = 0, dd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ad && dd)) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            dd = 1;
            s_axi_wvalid <= 0;
         end
      end
      do @(posedge clk_sys); while (!s_axi_bvalid);
      rd_r = s_axi_bresp;
   endtask
   task automatic rd(logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
   endtask
   // Timing is applied for one crossing only, then cleared
   task automatic xing(slr_ttc_s v);
      @(posedge clk_sys);
      ttc <= v;
      @(posedge clk_sys iff bc_en);
      rxs = rx_payload;
      @(posedge clk_sys);
      ttc <= '0;
      #1;
   endtask
   function automatic logic [7:0] enc(int p, slr_ttc_s v);
      case (p)
         0: return {6'h0, v.bchan, v.accept};
         1: return {4'h0, v.bchan, v.brcst[1:0], v.accept};
         2: return {4'h0, v.brcst[2:0], v.accept};
         3: return {v.bchan, v.brcst[5:0], v.accept};
         4: return {v.accept, v.brcst[3:0], v.accept, v.brcst[5], v.brcst[1]};
         5: return {4'h0, {4{v.brcst[0]}}};
         default: return {6'h0, {2{v.brcst[0]}}};
      endcase
   endfunction
   initial begin
      void'($urandom(6816));
      repeat (5) @(posedge clk_sys);
      nrst <= 1;
      @(posedge clk_sys);
      for (k = 0; k < 4; k++) begin
         rd(12'(4 * k));
         chk("reg reset", rd_d, 0);
      end
      rd(12'h020);
      chk("unmapped", {rd_r, rd_d}, {2'b10, 32'h0});
      wr(12'h020, 32'h0000_0000);
      chk("bresp", rd_r, 2'b10);
      chk("id0", host_id0, 0);
      wr(`SLR_OFF_ENABLE, 32'h0000_0001);
      for (k = 0; k < 21; k++) begin
         o = opts[k % 7];
         n = (o == 3 || o == 4) ? 2 : ((o == 0 || o == 6) ? 0 : 1);
         msk = 8'((1 << (2 << n)) - 1);
         wr(`SLR_OFF_WIDTH, 32'(n));
         wr(`SLR_OFF_OPTION, 32'(o));
         t = 10'($urandom);
         xing(t);
         chk("hvalid", host_valid[1:0], 2'b01);
         chk("hdata", host_data[7:0] & msk, rxs[7:0] & msk);
         chk("ctlrx", ctl_rx, rxs[1:0]);
         if (n == 0) chk("idle", tx_payload[3:2], 2'b01);
         // The encoder's code reaches the frame one crossing later
         xing('0);
         chk("code", tx_payload[7:0] & msk, enc(o, t) & msk);
         xing('0);
         chk("repeat", tx_payload[7:0] & msk, enc(o, '0) & msk);
      end
      wr(`SLR_OFF_WIDTH, 32'h0000_0003);
      xing('0);
      chk("w16", host_valid[0], 0);
      wr(`SLR_OFF_MODE, 32'h0000_0003);
      xing('0);
      chk("wide", {wide_valid, host_data}, {1'b1, rxs});
      chk("ctl8b10b", ctl_tx, 0);
      wr(`SLR_OFF_MODE, 32'h0000_0000);
      wr(`SLR_OFF_WIDTH, 32'h0000_0002);
      wr(`SLR_OFF_OPTION, 32'h0000_0007);
      t = '0;
      t.brcst[7] = 1;
      xing(t);
      xing('0);
      chk("ocr", tx_payload[3], 1);
      xing('0);
      chk("ocr2", tx_payload[3], 1);
      xing('0);
      chk("ocr end", tx_payload[3], 0);
      chk("flag", ctl_tx == 2'b00, 0);
      t = '0;
      t.brcst[2] = 1;
      xing(t);
      for (k = 1; k < 18; k++) begin
         xing('0);
         chk("pulse", tx_payload[5], k < 17);
      end
      wr(`SLR_OFF_MODE, 32'h0000_0004);
      wr(`SLR_OFF_ENABLE, 32'h8100_0001);
      t = '0;
      t.accept = 1;
      xing(t);
      chk("b24", {host_valid[24], tx_payload[55:48]}, 9'h100);
      n = 0;
      o = 0;
      repeat (32) begin
         n += int'(info_valid);
         if (info_valid && n == 1) msk = info_data;
         if (info_valid && info_last && info_flush) o = n;
         @(posedge clk_sys);
         #1;
      end
      chk("info", {32'(n), 32'(o)}, {32'd26, 32'd26});
      chk("info byte0", msk, 8'h01);
      rd(`SLR_OFF_STATUS);
      chk("status", rd_d, 32'h0000_0014);
      give_verdict();
   end
endmodule
